// ---- hw/psl_linker.sv ----
// positioning sequencer: single, linked and dwell-linked operation data
// Behaviour
// - single-motion entry runs one move, stops
// - linked entry flows into next without stop
// - first single-motion entry ends the chain
// - at most four entries per chain
// - both linked kinds share that limit
// - five or more entries alarm at start
// - plain links need same direction, else alarm
// - entry 63 never links to entry 1
// - chain uses first entry's accel, decel; the move after a dwell loads its own
// - linked-motion-2 may reverse direction
// - dwell after each linked-motion-2 move except one at entry 63
// - motion output drops before dwell
// - dwell end starts next move, motion up
// - ready drops on start; host releases
// - ready returns only when all done
// - select and start may rise together
// - select forms entry 1..63, zero sequential
// - stop input halts the operation
// - absolute position measured from home
// - incremental starts from current position
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module psl_linker #(
    parameter int DWELL_TICK = psl_pkg::DWELL_TICK_CYC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    // register port
    input  wire logic [11:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // host handshake
    input  wire logic                  select_bit0,
    input  wire logic                  select_bit1,
    input  wire logic                  select_bit2,
    input  wire logic                  select_bit3,
    input  wire logic                  select_bit4,
    input  wire logic                  select_bit5,
    input  wire logic                  start_in,
    input  wire logic                  stop_in,
    output logic                       ready,
    output logic                       motion_active,
    output logic                       op_data_alarm,
    // profile generator
    input  wire logic signed [31:0]    cur_pos,
    input  wire logic                  move_done,
    output logic                       move_go,
    output logic                       move_abort,
    output psl_pkg::psl_move_cmd_t     move_cmd
);

    typedef enum logic [2:0] {
        S_IDLE, S_CHECK, S_LOAD, S_MOVE, S_DWELL
    } psl_state_t;

    // entry table; word index is {entry, field}
    logic [31:0] mem [0:255];

    function automatic logic [7:0] wix(input logic [5:0] e,
                                       input logic [1:0] f);
        return {e, f};
    endfunction

    function automatic logic [1:0] fn_of(input logic [31:0] ctl);
        return ctl[psl_pkg::CTL_FN_LO +: 2];
    endfunction

    psl_state_t             state_r, state_nxt;
    logic [5:0]             idx_r, idx_nxt;
    logic [5:0]             scan_r, scan_nxt;
    logic [2:0]             cnt_r, cnt_nxt;
    logic [5:0]             seq_r, seq_nxt;
    logic                   link_r, link_nxt;
    logic                   dir_r, dir_nxt;
    logic [1:0]             pfn_r, pfn_nxt;
    logic [15:0]            dwell_r, dwell_nxt;
    logic [31:0]            div_r, div_nxt;
    logic                   ready_r, ready_nxt;
    logic                   motion_r, motion_nxt;
    logic                   alarm_r, alarm_nxt;
    logic                   go_r, go_nxt;
    logic                   abort_r, abort_nxt;
    psl_pkg::psl_move_cmd_t cmd_r, cmd_nxt;
    logic [31:0]            rdata_r, rdata_nxt;

    logic [5:0]             sel;
    logic [31:0]            ctl_w, pos_w, scan_ctl;
    logic signed [31:0]     base, tgt, posx;
    logic                   dir;
    logic [1:0]             fn;
    logic                   at_last;

    assign reg_rdata     = rdata_r;
    assign ready         = ready_r;
    assign motion_active = motion_r;
    assign op_data_alarm = alarm_r;
    assign move_go       = go_r;
    assign move_abort    = abort_r;
    assign move_cmd      = cmd_r;

    assign sel = {select_bit5, select_bit4, select_bit3,
                  select_bit2, select_bit1, select_bit0};

    assign ctl_w    = mem[wix(idx_r, psl_pkg::FLD_CTL)];
    assign pos_w    = mem[wix(idx_r, psl_pkg::FLD_POS)];
    assign scan_ctl = mem[wix(scan_r, psl_pkg::FLD_CTL)];
    assign fn       = fn_of(ctl_w);
    // no wrap past the last entry
    assign at_last  = (idx_r == psl_pkg::LAST_ENTRY);
    assign posx     = {{(32 - psl_pkg::POS_W){pos_w[psl_pkg::POS_W - 1]}},
                       pos_w[psl_pkg::POS_W - 1:0]};
    // linked moves continue from the previous target
    assign base     = link_r ? cmd_r.target : cur_pos;
    assign tgt      = ctl_w[psl_pkg::CTL_ABS_BIT] ? posx : base + posx;
    assign dir      = (tgt < base);

    // register bus; table writes need no reset
    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr[11:10] == psl_pkg::TABLE_PAGE) begin
            mem[reg_addr[9:2]] <= reg_wdata;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            if (reg_addr[11:10] == psl_pkg::TABLE_PAGE) begin
                rdata_nxt = mem[reg_addr[9:2]];
            end else if (reg_addr == psl_pkg::REG_STATUS) begin
                rdata_nxt[psl_pkg::ST_READY]         = ready_r;
                rdata_nxt[psl_pkg::ST_MOTION]        = motion_r;
                rdata_nxt[psl_pkg::ST_ALARM]         = alarm_r;
                rdata_nxt[psl_pkg::ST_SEQ_LO +: 6]   = seq_r;
                rdata_nxt[psl_pkg::ST_ENTRY_LO +: 6] = idx_r;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // sequencer
    always_comb begin
        state_nxt  = state_r;
        idx_nxt    = idx_r;
        scan_nxt   = scan_r;
        cnt_nxt    = cnt_r;
        seq_nxt    = seq_r;
        link_nxt   = link_r;
        dir_nxt    = dir_r;
        pfn_nxt    = pfn_r;
        dwell_nxt  = dwell_r;
        div_nxt    = div_r;
        ready_nxt  = ready_r;
        motion_nxt = motion_r;
        alarm_nxt  = alarm_r;
        cmd_nxt    = cmd_r;
        go_nxt     = 1'b0;
        abort_nxt  = 1'b0;
        // software clear; any set below wins
        if (reg_wr && reg_addr == psl_pkg::REG_CONTROL &&
            reg_wdata[psl_pkg::CTL_ALM_CLR]) begin
            alarm_nxt = 1'b0;
        end
        case (state_r)
            S_IDLE: begin
                // ready only when idle and clear of alarm
                ready_nxt  = !alarm_nxt;
                motion_nxt = 1'b0;
                // select sampled in the start cycle itself
                if (start_in && ready_r && !stop_in) begin
                    ready_nxt = 1'b0;
                    idx_nxt   = (sel == 6'h0) ? seq_r : sel;
                    scan_nxt  = (sel == 6'h0) ? seq_r : sel;
                    cnt_nxt   = 3'h1;
                    state_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                // chain ends at single-motion or the last entry
                if (fn_of(scan_ctl) == psl_pkg::FN_SINGLE ||
                    scan_r == psl_pkg::LAST_ENTRY) begin
                    link_nxt  = 1'b0;
                    state_nxt = S_LOAD;
                // fifth entry found before the move starts
                end else if (cnt_r == psl_pkg::MAX_CHAIN) begin
                    alarm_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end else begin
                    cnt_nxt  = cnt_r + 3'h1;
                    scan_nxt = scan_r + 6'h1;
                end
            end
            S_LOAD: begin
                // plain link must keep its direction
                if (link_r && pfn_r == psl_pkg::FN_LINKED &&
                    dir != dir_r && tgt != base) begin
                    alarm_nxt  = 1'b1;
                    abort_nxt  = 1'b1;
                    motion_nxt = 1'b0;
                    state_nxt  = S_IDLE;
                end else begin
                    cmd_nxt.target = tgt;
                    cmd_nxt.speed  = pos_w[0] ? mem[wix(idx_r,
                        psl_pkg::FLD_SPD)][psl_pkg::SPD_W - 1:0]
                        : mem[wix(idx_r,
                        psl_pkg::FLD_SPD)][psl_pkg::SPD_W - 1:0];
                    // ramps stay those of the chain head or of the move after the last dwell
                    if (!link_r) begin
                        cmd_nxt.accel = mem[wix(idx_r,
                                            psl_pkg::FLD_ACC)][31:16];
                        cmd_nxt.decel = mem[wix(idx_r,
                                            psl_pkg::FLD_ACC)][15:0];
                    end
                    // generator told not to stop here
                    cmd_nxt.link = (fn == psl_pkg::FN_LINKED) && !at_last;
                    dir_nxt      = dir;
                    pfn_nxt      = fn;
                    go_nxt       = 1'b1;
                    // motion rises with the move request
                    motion_nxt   = 1'b1;
                    state_nxt    = S_MOVE;
                end
            end
            S_MOVE: begin
                if (move_done) begin
                    if (fn == psl_pkg::FN_LINKED && !at_last) begin
                        idx_nxt   = idx_r + 6'h1;
                        link_nxt  = 1'b1;
                        state_nxt = S_LOAD;
                    // dwell link has no direction check
                    end else if (fn == psl_pkg::FN_LINKED2 && !at_last) begin
                        motion_nxt = 1'b0;
                        dwell_nxt  = ctl_w[psl_pkg::CTL_DWELL_LO +: 16];
                        div_nxt    = 32'h0;
                        state_nxt  = S_DWELL;
                    end else begin
                        motion_nxt = 1'b0;
                        state_nxt  = S_IDLE;
                        seq_nxt    = (ctl_w[psl_pkg::CTL_SEQ_BIT] && !at_last)
                                     ? idx_r + 6'h1 : psl_pkg::FIRST_ENTRY;
                    end
                end
            end
            S_DWELL: begin
                // hold still for the dwell count
                if (dwell_r == 16'h0) begin
                    idx_nxt   = idx_r + 6'h1;
                    link_nxt  = 1'b0;
                    state_nxt = S_LOAD;
                end else if (div_r == 32'(DWELL_TICK - 1)) begin
                    div_nxt   = 32'h0;
                    dwell_nxt = dwell_r - 16'h1;
                end else begin
                    div_nxt = div_r + 32'h1;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (stop_in && state_r != S_IDLE) begin
            state_nxt  = S_IDLE;
            abort_nxt  = 1'b1;
            go_nxt     = 1'b0;
            motion_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r  <= S_IDLE;
            idx_r    <= psl_pkg::FIRST_ENTRY;
            scan_r   <= psl_pkg::FIRST_ENTRY;
            cnt_r    <= 3'h0;
            seq_r    <= psl_pkg::FIRST_ENTRY;
            link_r   <= 1'b0;
            dir_r    <= 1'b0;
            pfn_r    <= psl_pkg::FN_SINGLE;
            dwell_r  <= 16'h0;
            div_r    <= 32'h0;
            ready_r  <= 1'b0;
            motion_r <= 1'b0;
            alarm_r  <= 1'b0;
            go_r     <= 1'b0;
            abort_r  <= 1'b0;
            cmd_r    <= '0;
        end else begin
            state_r  <= state_nxt;
            idx_r    <= idx_nxt;
            scan_r   <= scan_nxt;
            cnt_r    <= cnt_nxt;
            seq_r    <= seq_nxt;
            link_r   <= link_nxt;
            dir_r    <= dir_nxt;
            pfn_r    <= pfn_nxt;
            dwell_r  <= dwell_nxt;
            div_r    <= div_nxt;
            ready_r  <= ready_nxt;
            motion_r <= motion_nxt;
            alarm_r  <= alarm_nxt;
            go_r     <= go_nxt;
            abort_r  <= abort_nxt;
            cmd_r    <= cmd_nxt;
        end
    end

endmodule

// ---- hw/psl_pkg.sv ----
// constants, register map and carrier types of the positioning sequence linker
package psl_pkg;
    // operation data table
    localparam int          ENTRY_W      = 6;
    localparam logic [5:0]  LAST_ENTRY   = 6'h3f;
    localparam logic [5:0]  FIRST_ENTRY  = 6'h01;
    localparam logic [2:0]  MAX_CHAIN    = 3'h4;
    localparam logic [1:0]  FLD_POS      = 2'h0;
    localparam logic [1:0]  FLD_SPD      = 2'h1;
    localparam logic [1:0]  FLD_ACC      = 2'h2;
    localparam logic [1:0]  FLD_CTL      = 2'h3;

    // control word of an entry
    localparam int          CTL_ABS_BIT  = 0;
    localparam int          CTL_FN_LO    = 1;
    localparam int          CTL_SEQ_BIT  = 3;
    localparam int          CTL_DWELL_LO = 16;
    localparam int          POS_W        = 24;
    localparam int          SPD_W        = 20;

    // operation function codes
    localparam logic [1:0]  FN_SINGLE    = 2'h0;
    localparam logic [1:0]  FN_LINKED    = 2'h1;
    localparam logic [1:0]  FN_LINKED2   = 2'h2;

    // register map, byte addresses
    localparam int          ADDR_W       = 12;
    localparam logic [1:0]  TABLE_PAGE   = 2'h0;
    localparam logic [11:0] REG_STATUS   = 12'h400;
    localparam logic [11:0] REG_CONTROL  = 12'h404;
    localparam int          ST_READY     = 0;
    localparam int          ST_MOTION    = 1;
    localparam int          ST_ALARM     = 2;
    localparam int          ST_SEQ_LO    = 8;
    localparam int          ST_ENTRY_LO  = 16;
    localparam int          CTL_ALM_CLR  = 0;

    // dwell time base
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          DWELL_UNIT_NS  = 1000000;
    localparam int          DWELL_TICK_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic signed [31:0] target;
        logic [19:0]        speed;
        logic [15:0]        accel;
        logic [15:0]        decel;
        logic               link;
    } psl_move_cmd_t;
endpackage

// ---- verification/psl_linker_properties.sv ----
// timing checks on the ports of the positioning sequence linker
module psl_linker_properties #(
    parameter int DWELL_TICK = 4
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   arst_n,
    // register port
    input wire logic [11:0]            reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    // host handshake
    input wire logic                   start_in,
    input wire logic                   stop_in,
    input wire logic                   ready,
    input wire logic                   motion_active,
    input wire logic                   op_data_alarm,
    // profile generator
    input wire logic                   move_done,
    input wire logic                   move_go,
    input wire logic                   move_abort,
    input wire psl_pkg::psl_move_cmd_t move_cmd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_READY_DROP: assert property (
        start_in && ready && !stop_in |=> !ready)
        else $error("ready still high after accepted start");
    AST_FIRST_GO: assert property ($fell(ready) && !stop_in |->
        ##[1:6] (move_go || op_data_alarm || stop_in))
        else $error("no move or alarm after start");
    AST_GO_MOTION: assert property (move_go |-> motion_active)
        else $error("move issued without motion output");
    AST_IDLE_QUIET: assert property (
        ready |-> !move_go && !motion_active)
        else $error("ready high while moving");
    AST_STOP: assert property (
        stop_in && motion_active |=> move_abort && !motion_active)
        else $error("stop did not halt the move");
    AST_GO_PULSE: assert property (move_go |=> !move_go)
        else $error("move request longer than one cycle");
    AST_CMD_HOLD: assert property (!move_go |-> $stable(move_cmd))
        else $error("move command changed without a new move");
    AST_ALARM_LATCH: assert property (
        op_data_alarm && !(reg_wr && reg_wdata[0]
        && reg_addr[11:2] == psl_pkg::REG_CONTROL[11:2]) |=> op_data_alarm)
        else $error("alarm dropped without a clear");
    AST_ALARM_NO_GO: assert property (
        op_data_alarm |-> !move_go && !ready)
        else $error("move or ready during alarm");
    AST_MOTION_FALL: assert property ($fell(motion_active) |->
        $past(move_done) || $past(stop_in) || op_data_alarm)
        else $error("motion dropped while a move was running");

    COV_GO: cover property (move_go);
    COV_ALARM: cover property ($rose(op_data_alarm));
    COV_ABORT: cover property (move_abort);
    COV_DONE: cover property ($rose(ready));
endmodule

bind psl_linker psl_linker_properties #(.DWELL_TICK(DWELL_TICK))
    psl_linker_properties_inst (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_in(start_in),
    .stop_in(stop_in), .ready(ready), .motion_active(motion_active),
    .op_data_alarm(op_data_alarm), .move_done(move_done),
    .move_go(move_go), .move_abort(move_abort), .move_cmd(move_cmd));

// ---- verification/psl_gen_model.sv ----
// profile generator stand-in: ends each move after a set delay
module psl_gen_model (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // move requests
    input  wire logic [7:0]             lat,
    input  wire logic                   move_go,
    input  wire logic                   move_abort,
    input  wire psl_pkg::psl_move_cmd_t move_cmd,
    // answers
    output logic                        move_done,
    output logic signed [31:0]          cur_pos
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]         cnt;
    logic signed [31:0] tgt;

    // an abort leaves the position where the move started
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            tgt <= 32'sh0;
            move_done <= 1'b0;
            cur_pos <= 32'sh0;
        end else begin
            move_done <= 1'b0;
            if (move_abort) begin
                cnt <= 8'h00;
            end else if (move_go) begin
                cnt <= lat;
                tgt <= move_cmd.target;
            end else if (cnt == 8'h01) begin
                cnt <= 8'h00;
                move_done <= 1'b1;
                cur_pos <= tgt;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ---- verification/tb_psl_linker.sv ----
// self-checking bench for the positioning sequence linker
module tb_psl_linker;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, reg_wr, reg_rd, start_in, stop_in;
    logic ready, motion_active, op_data_alarm, move_done, move_go, move_abort;
    logic [11:0]            reg_addr;
    logic [31:0]            reg_wdata, reg_rdata, rd;
    logic [5:0]             sel;
    logic [7:0]             lat;
    logic signed [31:0]     cur_pos;
    psl_pkg::psl_move_cmd_t move_cmd;
    int                     err_total, checks, lo;
    logic [31:0]            tg[$], ac[$], sp[$];
    int                     gp[$];

    psl_linker #(.DWELL_TICK(4)) psl_linker_inst (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .select_bit0(sel[0]),
        .select_bit1(sel[1]), .select_bit2(sel[2]), .select_bit3(sel[3]),
        .select_bit4(sel[4]), .select_bit5(sel[5]), .start_in(start_in),
        .stop_in(stop_in), .ready(ready), .motion_active(motion_active),
        .op_data_alarm(op_data_alarm), .cur_pos(cur_pos),
        .move_done(move_done), .move_go(move_go), .move_abort(move_abort),
        .move_cmd(move_cmd));
    psl_gen_model psl_gen_model_inst (.clk(clk), .arst_n(arst_n), .lat(lat),
        .move_go(move_go), .move_abort(move_abort), .move_cmd(move_cmd),
        .move_done(move_done), .cur_pos(cur_pos));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // gp holds the idle cycles seen just before each move
    always @(posedge clk) begin
        if (move_go === 1'b1) begin
            tg.push_back(move_cmd.target);
            ac.push_back({move_cmd.accel, move_cmd.decel});
            sp.push_back({11'h000, move_cmd.link, move_cmd.speed});
            gp.push_back(lo);
        end
        lo <= (motion_active === 1'b0 && ready === 1'b0) ? lo + 1 : 0;
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic ent(input int n, input logic [31:0] p, input logic [1:0] f,
                       input logic ab, input logic [15:0] acc, dw);
        wr(12'(n * 16), {8'h00, p[23:0]});
        wr(12'(n * 16 + 4), 32'h00000400);
        wr(12'(n * 16 + 8), {acc, acc});
        wr(12'(n * 16 + 12), {dw, 12'h000, 1'b0, f, ab});
    endtask

    task automatic wait_ready(input int lim);
        int i;
        i = 0;
        while (ready !== 1'b1 && op_data_alarm !== 1'b1 && i < lim) begin
            @(posedge clk);
            i++;
        end
        chk("op end", 32'h1, {31'h0, i < lim});
    endtask

    task automatic run(input logic [5:0] s);
        int i;
        tg.delete();
        ac.delete();
        sp.delete();
        gp.delete();
        wait_ready(50);
        @(posedge clk);
        sel <= s;
        start_in <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ready !== 1'b0 && i < 50);
        start_in <= 1'b0;
        wait_ready(400);
    endtask

    task automatic clr_alarm;
        wr(psl_pkg::REG_CONTROL, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("alarm cleared", 32'h1, {31'h0, ready});
    endtask

    task automatic t_regs;
        rdr(psl_pkg::REG_STATUS);
        chk("status", 32'h1, {29'h0, rd[2:0]});
        rdr(12'h800);
        chk("unmapped", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic t_moves;
        run(6'h01);
        chk("single n", 32'h1, tg.size());
        chk("single tgt", 32'd5000, tg[0]);
        chk("single spd", 32'h00000400, sp[0]);
        run(6'h02);
        chk("link n", 32'h2, tg.size());
        chk("link gap", 32'h0, gp[1]);
        chk("link flag", 32'h00100400, sp[0]);
        chk("link abs", 32'd6000, tg[1]);
        chk("link ramp", 32'h00110011, ac[1]);
        run(6'h04);
        chk("dw tgt", 32'd6050, tg[1]);
        chk("dw gap", 32'h1, {31'h0, gp[1] >= 5 && gp[1] <= 7});
        chk("dw alarm", 32'h0, {31'h0, op_data_alarm});
        run(6'h14);
        chk("chain4 n", 32'h4, tg.size());
        chk("chain4 tgt", 32'd6054, tg[3]);
        $display("test moves done");
    endtask

    task automatic t_alarms;
        run(6'h0a);
        chk("five alarm", 32'h1, {31'h0, op_data_alarm});
        chk("five n", 32'h0, tg.size());
        rdr(psl_pkg::REG_STATUS);
        chk("alarm bit", 32'h1, {31'h0, rd[2]});
        clr_alarm();
        run(6'h1e);
        chk("dir alarm", 32'h1, {31'h0, op_data_alarm});
        clr_alarm();
        run(6'h3f);
        chk("e63 n", 32'h1, tg.size());
        chk("e63 tgt", 32'd7000, tg[0]);
        run(6'h00);
        chk("seq tgt", 32'd12000, tg[0]);
        $display("test alarms done");
    endtask

    task automatic t_stop;
        int i;
        tg.delete();
        lat <= 8'd20;
        wait_ready(50);
        @(posedge clk);
        sel <= 6'h01;
        start_in <= 1'b1;
        i = 0;
        while (motion_active !== 1'b1 && i < 20) begin
            @(posedge clk);
            i++;
        end
        start_in <= 1'b0;
        stop_in <= 1'b1;
        @(posedge clk);
        stop_in <= 1'b0;
        wait_ready(10);
        chk("stop ready", 32'h1, {31'h0, ready});
        chk("stop motion", 32'h0, {31'h0, motion_active});
        chk("stop pos", 32'd12000, cur_pos);
        $display("test stop done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        {arst_n, reg_wr, reg_rd, start_in, stop_in} = 5'h00;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        sel = 6'h00;
        lat = 8'd3;
        err_total = 0;
        checks = 0;
        lo = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        ent(1, 32'd5000, psl_pkg::FN_SINGLE, 1'b0, 16'h0005, 16'h0);
        ent(2, 32'd100, psl_pkg::FN_LINKED, 1'b0, 16'h0011, 16'h0);
        ent(3, 32'd6000, psl_pkg::FN_SINGLE, 1'b1, 16'h0099, 16'h0);
        ent(4, 32'd100, psl_pkg::FN_LINKED2, 1'b0, 16'h0007, 16'h1);
        ent(5, -32'sd50, psl_pkg::FN_SINGLE, 1'b0, 16'h0007, 16'h0);
        for (int k = 10; k < 15; k++)
            ent(k, 32'd1, k < 14 ? psl_pkg::FN_LINKED : psl_pkg::FN_SINGLE,
                1'b0, 16'h0003, 16'h0);
        ent(20, 32'd1, psl_pkg::FN_LINKED, 1'b0, 16'h0003, 16'h0);
        ent(21, 32'd1, psl_pkg::FN_LINKED2, 1'b0, 16'h0003, 16'h0);
        ent(22, 32'd1, psl_pkg::FN_LINKED, 1'b0, 16'h0003, 16'h0);
        ent(23, 32'd1, psl_pkg::FN_SINGLE, 1'b0, 16'h0003, 16'h0);
        ent(30, 32'd100, psl_pkg::FN_LINKED, 1'b0, 16'h0003, 16'h0);
        ent(31, -32'sd100, psl_pkg::FN_SINGLE, 1'b0, 16'h0003, 16'h0);
        ent(63, 32'd7000, psl_pkg::FN_LINKED, 1'b1, 16'h0003, 16'h0);
        t_regs();
        t_moves();
        t_alarms();
        t_stop();
        tally_and_finish();
    end
endmodule
